/* File: design/ballast_params.svh */
// constants for the ballast start-up sequencer: offsets, resets, timing
// assumes a 125 MHz system clock and a 1 us internal tick
`ifndef BALLAST_PARAMS_SVH
`define BALLAST_PARAMS_SVH
`define CLK_NS 8
`define TICK_NS 1000
`define TICK_CYC (`TICK_NS / `CLK_NS)
`define ADR_CTRL 8'h00
`define ADR_STAT 8'h04
`define CTRL_RESET 32'h0300_2d64
`define FPH_LSB 0
`define FRUN_LSB 8
`define TPH_LSB 16
`define LVSA_EN_BIT 24
`define LVSB_EN_BIT 25
`define F_START_KHZ 8'h87
`define NCO_K 16'h0086
`define DEAD_MIN_NS 1250
`define DEAD_MAX_NS 2500
`define DEAD_MIN_CYC ((`DEAD_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define DEAD_MAX_CYC (`DEAD_MAX_NS / `CLK_NS)
`define SOFT_STEPS 7'h0f
`define IGN_STEPS 7'h7f
`define T_WAIT_BUS_US 80
`define T_PFC_DLY_US 300
`define T_BUS_WIN_US 80000
`define T_SOFT_STEP_US 650
`define T_IGN_STEP_US 324
`define T_IGN_MAX_US 237000
`define T_PRERUN_US 625000
`define T_PH_STEP_US 19685
`endif

/* File: design/ballast_pkg.sv */
// types for the ballast start-up sequencer
// assumes nothing beyond the params header
package ballast_pkg;
  typedef enum logic [3:0] {
    ST_UVLO = 4'h0,
    ST_HYST = 4'h1,
    ST_WAIT_BUS = 4'h2,
    ST_START = 4'h3,
    ST_SOFT = 4'h4,
    ST_PREHEAT = 4'h5,
    ST_IGNITE = 4'h6,
    ST_PRERUN = 4'h7,
    ST_RUN = 4'h8,
    ST_HALT = 4'h9
  } phase_type;
  typedef enum logic [1:0] {
    RES_I_NORMAL = 2'h0,
    RES_I_LOW = 2'h1,
    RES_I_HS_OPEN = 2'h2,
    RES_I_HS_OPEN_LOW = 2'h3
  } res_current_type;
endpackage

/* File: design/ballast_startup_sequencer.sv */
// ballast start-up sequencer: phases, gate timing, wishbone registers
// assumes comparator flags are asynchronous; wishbone runs on clk_sys_i
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`include "ballast_params.svh"
module ballast_startup_sequencer
  import ballast_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYC,
  parameter int WAIT_BUS_T = `T_WAIT_BUS_US,
  parameter int PFC_DLY_T = `T_PFC_DLY_US,
  parameter int BUS_WIN_T = `T_BUS_WIN_US,
  parameter int SOFT_STEP_T = `T_SOFT_STEP_US,
  parameter int IGN_STEP_T = `T_IGN_STEP_US,
  parameter int IGN_MAX_T = `T_IGN_MAX_US,
  parameter int PRERUN_T = `T_PRERUN_US,
  parameter int PH_STEP_T = `T_PH_STEP_US
)(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vcc_lower_i,
  input wire logic vcc_upper_i,
  input wire logic high_side_supply_hi_i,
  input wire logic high_side_supply_lo_i,
  input wire logic bus_above_min_i,
  input wire logic bus_above_max_i,
  input wire logic bus_rated_i,
  input wire logic res_above_high_i,
  input wire logic res_above_low_i,
  input wire logic lamp_voltage_sense_a_i,
  input wire logic lamp_voltage_sense_b_i,
  input wire logic ignition_i,
  output logic low_side_gate_o,
  output logic high_side_gate_o,
  output logic pfc_gate_en_o,
  output logic monitor_en_o,
  output logic res_thresh_low_o,
  output res_current_type res_current_o,
  output logic [3:0] phase_o
);
  localparam int NSYNC = 12;
  localparam logic [15:0] DEAD_MIN = 16'(`DEAD_MIN_CYC);
  localparam logic [15:0] DEAD_MAX = 16'(`DEAD_MAX_CYC);

  // true once a tick counter has reached a limit
  function automatic logic reached(input logic [21:0] c, input int lim);
    return {10'h000, c} >= 32'(lim);
  endfunction

  // linear step from one frequency to another, k of n steps done
  function automatic logic [7:0] interp(input logic [7:0] f0, input logic [7:0] f1,
                                        input logic [6:0] k, input logic [6:0] n);
    logic [15:0] span;
    span = 16'h0000;
    if (f0 <= f1)
      return f1;
    span = 16'(f0 - f1) * 16'(n - k);
    return f1 + 8'(span / 16'(n));
  endfunction

  logic [NSYNC-1:0] async_in, sync1_q, sync2_q;
  logic vcc_lower_s, vcc_upper_s, hs_hi_s, hs_lo_s, bus_min_s, bus_max_s;
  logic bus_rated_s, res_hi_s, res_lo_s, lvs_a_s, lvs_b_s, ign_s;
  logic [31:0] ctrl_q;
  logic [7:0] fph, frun;
  logic [6:0] tph;
  phase_type state_q, state_d;
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic [21:0] phase_cnt_q, step_cnt_q;
  logic [6:0] step_k_q;
  logic lo_open_q, hi_open_q, fil_ok, hs_en_q, gates_on;
  logic [7:0] freq_q, freq_d;
  logic [23:0] acc_q;
  logic half_q;
  logic [15:0] hp_cnt_q, dead_q, dead_cnt_q;
  logic [15:0] hp_quarter;
  logic corridor_ok, step_end;

  // comparator flags pass two flops before use
  assign async_in = {vcc_lower_i, vcc_upper_i, high_side_supply_hi_i, high_side_supply_lo_i,
                     bus_above_min_i, bus_above_max_i, bus_rated_i, res_above_high_i,
                     res_above_low_i, lamp_voltage_sense_a_i, lamp_voltage_sense_b_i, ignition_i};
  always_ff @(posedge clk_sys_i)
  begin
    sync1_q <= async_in;
    sync2_q <= sync1_q;
  end
  assign {vcc_lower_s, vcc_upper_s, hs_hi_s, hs_lo_s, bus_min_s, bus_max_s,
          bus_rated_s, res_hi_s, res_lo_s, lvs_a_s, lvs_b_s, ign_s} = sync2_q;

  // wishbone slave: ack one cycle after request, unmapped reads zero
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        if (wb_we_i && wb_adr_i == `ADR_CTRL)
          for (int b = 0; b < 4; b++)
            if (wb_sel_i[b])
              ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
        if (!wb_we_i && wb_adr_i == `ADR_CTRL)
          wb_dat_o <= ctrl_q & 32'h037f_ffff;
        if (!wb_we_i && wb_adr_i == `ADR_STAT)
          wb_dat_o <= {16'h0000, freq_q, pfc_gate_en_o, hs_en_q, hi_open_q, lo_open_q, state_q};
      end
    end
  end
  assign fph = ctrl_q[`FPH_LSB +: 8];
  assign frun = ctrl_q[`FRUN_LSB +: 8];
  assign tph = ctrl_q[`TPH_LSB +: 7];

  // single internal tick drives every phase delay
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !vcc_lower_s)
    begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_cnt_q == 16'(TICK_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == 16'(TICK_CYC - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001;
    end
  end

  // high-side supply lockout with hysteresis
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      hs_en_q <= 1'b0;
    else if (hs_hi_s)
      hs_en_q <= 1'b1;
    else if (!hs_lo_s)
      hs_en_q <= 1'b0;
  end

  // filament detection while not switching
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || state_q == ST_UVLO)
    begin
      lo_open_q <= 1'b0;
      hi_open_q <= 1'b0;
    end
    else if (state_q == ST_HYST)
    begin
      hi_open_q <= (ctrl_q[`LVSA_EN_BIT] && !lvs_a_s) || (ctrl_q[`LVSB_EN_BIT] && !lvs_b_s);
      if (!lo_open_q && res_hi_s)
        lo_open_q <= 1'b1;
      else if (lo_open_q && !res_lo_s)
        lo_open_q <= 1'b0;
    end
  end
  assign fil_ok = !lo_open_q && !hi_open_q;
  assign corridor_ok = bus_min_s && !bus_max_s;
  assign step_end = (state_q == ST_SOFT) ? reached(step_cnt_q, SOFT_STEP_T) : reached(step_cnt_q, IGN_STEP_T);

  // phase sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_UVLO: if (vcc_lower_s) state_d = ST_HYST;
      ST_HYST: if (vcc_upper_s && fil_ok) state_d = ST_WAIT_BUS;
      ST_WAIT_BUS:
        if (reached(phase_cnt_q, WAIT_BUS_T))
          state_d = corridor_ok ? ST_START : ST_HALT;
      ST_START:
        if (bus_rated_s) state_d = ST_SOFT;
        else if (reached(phase_cnt_q, BUS_WIN_T)) state_d = ST_HALT;
      ST_SOFT: if (step_k_q == `SOFT_STEPS) state_d = ST_PREHEAT;
      ST_PREHEAT:
        if ({10'h000, phase_cnt_q} >= 32'(tph) * 32'(PH_STEP_T)) state_d = ST_IGNITE;
      ST_IGNITE:
        if (ign_s) state_d = ST_PRERUN;
        else if (reached(phase_cnt_q, IGN_MAX_T)) state_d = ST_HALT;
      ST_PRERUN: if (reached(phase_cnt_q, PRERUN_T)) state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      ST_HALT: state_d = ST_HALT;
      default: state_d = ST_UVLO;
    endcase
    if (!vcc_lower_s)
      state_d = ST_UVLO;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      state_q <= ST_UVLO;
    else
      state_q <= state_d;
  end

  // phase and step counters, cleared on each phase change
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || state_d != state_q || state_q == ST_UVLO)
    begin
      phase_cnt_q <= 22'h000000;
      step_cnt_q <= 22'h000000;
      step_k_q <= 7'h00;
    end
    else if (tick_q)
    begin
      phase_cnt_q <= phase_cnt_q + 22'h000001;
      if (step_end && step_k_q != `IGN_STEPS)
      begin
        step_cnt_q <= 22'h000000;
        step_k_q <= step_k_q + 7'h01;
      end
      else
        step_cnt_q <= step_cnt_q + 22'h000001;
    end
  end

  // inverter frequency per phase, in kHz
  always_comb
  begin
    unique case (state_q)
      ST_START: freq_d = `F_START_KHZ;
      ST_SOFT: freq_d = interp(`F_START_KHZ, fph, step_k_q, `SOFT_STEPS);
      ST_PREHEAT: freq_d = fph;
      ST_IGNITE: freq_d = interp(fph, frun, step_k_q, `IGN_STEPS);
      ST_PRERUN, ST_RUN: freq_d = frun;
      default: freq_d = 8'h00;
    endcase
  end
  assign gates_on = state_q inside {ST_START, ST_SOFT, ST_PREHEAT, ST_IGNITE, ST_PRERUN, ST_RUN};

  // half-bridge oscillator with adaptive dead time
  assign hp_quarter = hp_cnt_q >> 2;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !gates_on)
    begin
      acc_q <= 24'h000000;
      half_q <= 1'b0;
      hp_cnt_q <= 16'h0000;
      dead_q <= DEAD_MIN;
      dead_cnt_q <= DEAD_MIN;
      freq_q <= 8'h00;
    end
    else
    begin
      freq_q <= freq_d;
      acc_q <= acc_q + 24'(16'(freq_q) * `NCO_K);
      half_q <= acc_q[23];
      if (half_q != acc_q[23])
      begin
        hp_cnt_q <= 16'h0000;
        dead_cnt_q <= dead_q;
        dead_q <= (hp_quarter < DEAD_MIN) ? DEAD_MIN : (hp_quarter > DEAD_MAX) ? DEAD_MAX : hp_quarter;
      end
      else
      begin
        hp_cnt_q <= (hp_cnt_q == 16'hffff) ? hp_cnt_q : hp_cnt_q + 16'h0001;
        dead_cnt_q <= (dead_cnt_q == 16'h0000) ? dead_cnt_q : dead_cnt_q - 16'h0001;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      low_side_gate_o <= 1'b0;
      high_side_gate_o <= 1'b0;
      pfc_gate_en_o <= 1'b0;
      monitor_en_o <= 1'b0;
      res_thresh_low_o <= 1'b0;
      res_current_o <= RES_I_NORMAL;
      phase_o <= 4'h0;
    end
    else
    begin
      low_side_gate_o <= gates_on && !half_q && dead_cnt_q == 16'h0000;
      high_side_gate_o <= gates_on && hs_en_q && half_q && dead_cnt_q == 16'h0000;
      pfc_gate_en_o <= gates_on && (state_q != ST_START || reached(phase_cnt_q, PFC_DLY_T));
      monitor_en_o <= state_q == ST_RUN;
      res_thresh_low_o <= lo_open_q;
      res_current_o <= res_current_type'({hi_open_q, lo_open_q});
      phase_o <= state_q;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_hs_off;
    !hs_en_q |=> !high_side_gate_o;
  endproperty
  a_hs_off: assert property (p_hs_off) else $error("high gate while locked out");
  property p_hs_hyst;
    hs_en_q && hs_lo_s |=> hs_en_q;
  endproperty
  a_hs_hyst: assert property (p_hs_hyst) else $error("high side dropped inside hysteresis");
  property p_dead;
    gates_on |-> dead_q >= DEAD_MIN && dead_q <= DEAD_MAX;
  endproperty
  a_dead: assert property (p_dead) else $error("dead time out of range");
  property p_uvlo_idle;
    state_q == ST_UVLO |=> !low_side_gate_o && !pfc_gate_en_o && !monitor_en_o;
  endproperty
  a_uvlo_idle: assert property (p_uvlo_idle) else $error("activity in lockout");
  property p_wait;
    state_q == ST_WAIT_BUS && !reached(phase_cnt_q, WAIT_BUS_T) && vcc_lower_s |=> state_q == ST_WAIT_BUS;
  endproperty
  a_wait: assert property (p_wait) else $error("bus sampled early");
  property p_corr;
    state_q == ST_WAIT_BUS ##1 state_q == ST_START |-> $past(corridor_ok);
  endproperty
  a_corr: assert property (p_corr) else $error("started outside corridor");
  property p_pfc;
    state_q == ST_START && !reached(phase_cnt_q, PFC_DLY_T) |=> !pfc_gate_en_o;
  endproperty
  a_pfc: assert property (p_pfc) else $error("pfc enabled early");
  property p_bus_to;
    state_q == ST_START && !bus_rated_s && reached(phase_cnt_q, BUS_WIN_T) && vcc_lower_s
      |=> state_q == ST_HALT ##2 !low_side_gate_o;
  endproperty
  a_bus_to: assert property (p_bus_to) else $error("bus timeout not honoured");
  property p_fil;
    state_q == ST_HYST && !fil_ok |=> state_q != ST_WAIT_BUS;
  endproperty
  a_fil: assert property (p_fil) else $error("power-up with bad filament");
  property p_prerun;
    state_q == ST_PRERUN && !reached(phase_cnt_q, PRERUN_T) |=> !monitor_en_o;
  endproperty
  a_prerun: assert property (p_prerun) else $error("run entered early");

  c_run: cover property (state_q == ST_PRERUN ##1 state_q == ST_RUN);
  c_halt: cover property (state_q == ST_START ##1 state_q == ST_HALT);
  c_lo_open: cover property ($fell(lo_open_q) && state_q == ST_HYST);
endmodule

/* File: tb/ballast_analog_model.sv */
// comparator front end and lamp seen by the sequencer
// assumes the bench moves the analog levels just after a rising clock edge
`timescale 1ns/10ps
module ballast_analog_model (
  input wire logic [15:0] vcc_mv_i,
  input wire logic [15:0] hs_mv_i,
  input wire logic [15:0] bus_pm_i,
  input wire logic [15:0] res_mv_i,
  input wire logic [7:0] lvs_a_ua_i,
  input wire logic [7:0] lvs_b_ua_i,
  input wire logic lit_i,
  output logic vcc_lower_o,
  output logic vcc_upper_o,
  output logic hs_hi_o,
  output logic hs_lo_o,
  output logic bus_min_o,
  output logic bus_max_o,
  output logic bus_rated_o,
  output logic res_high_o,
  output logic res_low_o,
  output logic lvs_a_o,
  output logic lvs_b_o,
  output logic ignition_o
);
  // chip supply thresholds
  assign vcc_lower_o = vcc_mv_i > 16'd10600;
  assign vcc_upper_o = vcc_mv_i > 16'd14100;
  // floating supply pair, hysteresis is the sequencer's job
  assign hs_hi_o = hs_mv_i > 16'd10100;
  assign hs_lo_o = hs_mv_i > 16'd8400;
  // bus corridor and rated level in permille
  assign bus_min_o = bus_pm_i > 16'd125;
  assign bus_max_o = bus_pm_i > 16'd1050;
  assign bus_rated_o = bus_pm_i > 16'd950;
  // restart sense comparators
  assign res_high_o = res_mv_i > 16'd1600;
  assign res_low_o = res_mv_i > 16'd1300;
  // sink current present above 12 uA
  assign lvs_a_o = lvs_a_ua_i > 8'd12;
  assign lvs_b_o = lvs_b_ua_i > 8'd12;
  assign ignition_o = lit_i;
endmodule

/* File: tb/ballast_startup_sequencer_tb_top.sv */
// bench for the start-up sequencer: wishbone tasks and phase walk
// assumes shortened timing parameters, 2 clock cycles per tick
`timescale 1ns/10ps
module ballast_startup_sequencer_tb_top;
  import ballast_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_req = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'hf;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] vcc = 16'd0;
  logic [15:0] hs = 16'd0;
  logic [15:0] bus = 16'd0;
  logic [15:0] res = 16'd0;
  logic [7:0] lvs_a = 8'd20;
  logic [7:0] lvs_b = 8'd20;
  logic lit = 1'b0;
  logic vl, vu, hh, hl, bmin, bmax, brat, rh, rl, la, lb, ign;
  logic low_side_gate_o, high_side_gate_o, pfc_gate_en_o, monitor_en_o, res_thresh_low_o;
  res_current_type res_current_o;
  logic [3:0] phase_o;
  logic [31:0] rdat;
  logic prev_lo = 1'b0;
  logic seen_fall = 1'b0;
  int gap = 0;
  int cycles = 0;
  int failures = 0;
  int checked = 0;
  // 125 MHz clock
  always #4 clk_sys_i = ~clk_sys_i;
  // bus window, soft-start steps, preheat steps and prerun are shortened; bus wait, pfc delay, ignition steps and ignition timeout keep their real counts
  ballast_startup_sequencer #(.TICK_CYC(2), .BUS_WIN_T(400), .SOFT_STEP_T(2), .PRERUN_T(20), .PH_STEP_T(3))
    dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vcc_lower_i(vl), .vcc_upper_i(vu),
    .high_side_supply_hi_i(hh), .high_side_supply_lo_i(hl), .bus_above_min_i(bmin), .bus_above_max_i(bmax),
    .bus_rated_i(brat), .res_above_high_i(rh), .res_above_low_i(rl), .lamp_voltage_sense_a_i(la),
    .lamp_voltage_sense_b_i(lb), .ignition_i(ign), .low_side_gate_o(low_side_gate_o),
    .high_side_gate_o(high_side_gate_o), .pfc_gate_en_o(pfc_gate_en_o), .monitor_en_o(monitor_en_o),
    .res_thresh_low_o(res_thresh_low_o), .res_current_o(res_current_o), .phase_o(phase_o));
  ballast_analog_model ana_u (.vcc_mv_i(vcc), .hs_mv_i(hs), .bus_pm_i(bus), .res_mv_i(res), .lvs_a_ua_i(lvs_a),
    .lvs_b_ua_i(lvs_b), .lit_i(lit), .vcc_lower_o(vl), .vcc_upper_o(vu), .hs_hi_o(hh), .hs_lo_o(hl),
    .bus_min_o(bmin), .bus_max_o(bmax), .bus_rated_o(brat), .res_high_o(rh), .res_low_o(rl), .lvs_a_o(la),
    .lvs_b_o(lb), .ignition_o(ign));
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack is seen high at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_req <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_wdat <= dat;
    @(posedge clk_sys_i);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys_i);
    end
    chk({31'h0, wb_ack_o}, 32'h1);
    rd = wb_dat_o;
    wb_req <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, adr, 4'hf, 32'h0, rdat);
    chk(rdat & mask, exp);
  endtask
  task automatic wait_phase(input logic [3:0] p);
    int n;
    n = 0;
    while (phase_o !== p && n < 3000)
    begin
      n++;
      @(posedge clk_sys_i);
    end
    chk({28'h0, phase_o}, {28'h0, p});
  endtask
  // bridge watch: no overlap, gap from low fall to high rise
  always @(negedge clk_sys_i)
  begin
    if (low_side_gate_o === 1'b1 && high_side_gate_o === 1'b1)
      chk(32'h1, 32'h0);
    if (prev_lo === 1'b1 && low_side_gate_o === 1'b0)
    begin
      gap <= 0;
      seen_fall <= 1'b1;
    end
    else
      gap <= gap + 1;
    if (seen_fall && high_side_gate_o === 1'b1 && gap > 0 && gap < 2000)
    begin
      chk({31'h0, gap >= 156 && gap <= 312}, 32'h1);
      seen_fall <= 1'b0;
    end
    prev_lo <= low_side_gate_o;
  end
  // hang guard
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      failures++;
      print_verdict();
    end
  end
  // supply step just after a rising edge, no settle wait
  task automatic set_vcc(input logic [15:0] mv);
    @(posedge clk_sys_i);
    vcc <= mv;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk({25'h0, phase_o, low_side_gate_o, high_side_gate_o, pfc_gate_en_o}, 32'h0);
    rd_chk(8'h00, 32'hffff_ffff, 32'h0300_2d64);
    rd_chk(8'h40, 32'hffff_ffff, 32'h0);
    // only the third byte lane may land
    wb(1'b1, 8'h00, 4'h4, 32'hff02_ffff, rdat);
    rd_chk(8'h00, 32'hffff_ffff, 32'h0302_2d64);
    // open filaments hold the hysteresis phase
    set_vcc(16'd11000);
    wait_phase(4'h1);
    res <= 16'd1700;
    lvs_a <= 8'd0;
    set_vcc(16'd15000);
    repeat (40) @(posedge clk_sys_i);
    chk({31'h0, res_thresh_low_o}, 32'h1);
    chk({30'h0, res_current_o}, 32'h3);
    chk({28'h0, phase_o}, 32'h1);
    lvs_a <= 8'd20;
    res <= 16'd1400;
    repeat (40) @(posedge clk_sys_i);
    chk({30'h0, res_current_o}, 32'h1);
    chk({28'h0, phase_o}, 32'h1);
    // corridor misses on both sides end in halt
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys_i);
      bus <= (i == 0) ? 16'd100 : 16'd1100;
      res <= 16'd1000;
      set_vcc(16'd15000);
      wait_phase(4'h2);
      repeat (4) @(posedge clk_sys_i);
      chk({28'h0, phase_o}, 32'h2);
      wait_phase(4'h9);
      set_vcc(16'd12000);
      repeat (20) @(posedge clk_sys_i);
      chk({27'h0, phase_o, low_side_gate_o}, 32'h12);
      set_vcc(16'd9000);
      wait_phase(4'h0);
      repeat (3) @(posedge clk_sys_i);
      chk({30'h0, high_side_gate_o, low_side_gate_o}, 32'h0);
    end
    // switching starts, but the bus never reaches rated level
    bus <= 16'd500;
    set_vcc(16'd15000);
    wait_phase(4'h3);
    rd_chk(8'h04, 32'h0000_ff00, 32'h0000_8700);
    chk({31'h0, pfc_gate_en_o}, 32'h0);
    // 300 ticks of 2 cycles, well inside the 400 tick bus window
    repeat (620) @(posedge clk_sys_i);
    chk({31'h0, pfc_gate_en_o}, 32'h1);
    wait_phase(4'h9);
    repeat (3) @(posedge clk_sys_i);
    chk({29'h0, low_side_gate_o, high_side_gate_o, pfc_gate_en_o}, 32'h0);
    set_vcc(16'd9000);
    wait_phase(4'h0);
    // full start to run
    hs <= 16'd11000;
    set_vcc(16'd15000);
    wait_phase(4'h3);
    bus <= 16'd960;
    wait_phase(4'h4);
    wait_phase(4'h5);
    rd_chk(8'h04, 32'h0000_ff00, 32'h0000_6400);
    wait_phase(4'h6);
    // one ignition step is 325 ticks, so wait past the first step
    repeat (700) @(posedge clk_sys_i);
    wb(1'b0, 8'h04, 4'hf, 32'h0, rdat);
    chk({31'h0, rdat[15:8] < 8'h64 && rdat[15:8] >= 8'h2d}, 32'h1);
    lit <= 1'b1;
    wait_phase(4'h7);
    repeat (30) @(posedge clk_sys_i);
    chk({27'h0, phase_o, monitor_en_o}, 32'he);
    wait_phase(4'h8);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, monitor_en_o}, 32'h1);
    // floating supply hysteresis
    rd_chk(8'h04, 32'h40, 32'h40);
    hs <= 16'd9000;
    repeat (10) @(posedge clk_sys_i);
    rd_chk(8'h04, 32'h40, 32'h40);
    hs <= 16'd8000;
    repeat (10) @(posedge clk_sys_i);
    rd_chk(8'h04, 32'h40, 32'h0);
    chk({31'h0, high_side_gate_o}, 32'h0);
    hs <= 16'd9000;
    repeat (10) @(posedge clk_sys_i);
    rd_chk(8'h04, 32'h40, 32'h0);
    print_verdict();
  end
endmodule
